// ### rtl/dsd_pkg.sv
// Constants and types for the data space decoder with program window.
// Assumes one core clock and an active-low asynchronous reset.
package dsd_pkg;

  localparam int ADDR_W = 16;
  localparam int DATA_W = 16;
  localparam int PROG_W = 24;
  localparam int PAGE_W = 8;
  localparam int WIN_LOW_W = 15;
  localparam int RAM_WORDS = 256;
  localparam int IDX_W = 8;

  // Fixed data space map
  localparam logic [15:0] SFA_LIMIT = 16'h0800;
  localparam logic [15:0] XRAM_BASE = 16'h0800;
  localparam logic [15:0] YRAM_BASE = 16'h0900;
  localparam logic [15:0] YRAM_LAST = 16'h09ff;
  localparam logic [15:0] WIN_BASE = 16'h8000;

  // Reset values
  localparam logic [15:0] DATA_RST = 16'h0000;
  localparam logic [23:0] PADDR_RST = 24'h000000;
  localparam logic [1:0] CNT_RST = 2'h0;

  // Extra instruction cycles for a windowed access
  localparam logic [1:0] EXTRA_LIGHT = 2'h1;
  localparam logic [1:0] EXTRA_FULL = 2'h2;
  localparam logic [1:0] EXTRA_RPT_EDGE = 2'h2;
  localparam logic [1:0] EXTRA_RPT_MID = 2'h0;

  typedef enum logic [1:0] {
    DSD_IDLE = 2'b01,
    DSD_WAIT = 2'b10
  } dsd_state_e;

endpackage

// ### rtl/dsd_ram_if.sv
// Connection between the decoder and its word-wide data RAM.
// Assumes the RAM answers reads combinationally from its index.
`timescale 1ns/1ps
interface dsd_ram_if;
  import dsd_pkg::*;
  logic [IDX_W-1:0] x_idx;
  logic [IDX_W-1:0] y_idx;
  logic [DATA_W-1:0] x_q;
  logic [DATA_W-1:0] y_q;
  logic wr_en;
  logic [IDX_W-1:0] wr_idx;
  logic [DATA_W-1:0] wr_data;
  logic [1:0] wr_be;

  modport ctrl (output x_idx, y_idx, wr_en, wr_idx, wr_data, wr_be, input x_q, y_q);
  modport mem (input x_idx, y_idx, wr_en, wr_idx, wr_data, wr_be, output x_q, y_q);
endinterface

// ### rtl/dsd_ram.sv
// Data RAM of 256 words, byte writable, two read ports.
// Assumes the write index and enables arrive from the decoder clock domain.
`timescale 1ns/1ps
module dsd_ram
  import dsd_pkg::*;
(
  input wire logic clock, // Core clock
  input wire logic arst_n, // Async reset
  dsd_ram_if.mem ram // Ports to the decoder
);

  logic [DATA_W-1:0] mem_ff [RAM_WORDS];

  // One storage word per entry, each byte lane written on its own
  for (genvar i = 0; i < RAM_WORDS; i++) begin : g_word
    logic [DATA_W-1:0] nxt_word;
    always_comb begin
      nxt_word = mem_ff[i];
      if (ram.wr_en && ram.wr_idx == IDX_W'(i)) begin
        if (ram.wr_be[0]) nxt_word[7:0] = ram.wr_data[7:0];
        if (ram.wr_be[1]) nxt_word[15:8] = ram.wr_data[15:8];
      end
    end
    always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) mem_ff[i] <= DATA_RST;
      else mem_ff[i] <= nxt_word;
    end
  end

  // Two independent read ports
  assign ram.x_q = mem_ff[ram.x_idx];
  assign ram.y_q = mem_ff[ram.y_idx];

endmodule

// ### rtl/dsd_cycle.sv
// Extra instruction cycle accounting for program window accesses.
// Assumes the sequencer gives the class and repeat status with the start.
`timescale 1ns/1ps
module dsd_cycle
  import dsd_pkg::*;
(
  input wire logic clock, // Core clock
  input wire logic arst_n, // Async reset
  input wire logic start, // Windowed access begins
  input wire logic light_class, // MAC prefetch, move or double move
  input wire logic in_repeat, // Inside a repeat loop
  input wire logic rpt_edge, // First, last, interrupt exit or re-entry
  output logic stall // Extra cycle in progress
);

  logic [1:0] cnt_ff;
  logic [1:0] nxt_cnt;
  logic [1:0] extra;

  // Pick the cost of this access
  always_comb begin
    if (in_repeat) begin
      if (rpt_edge) extra = EXTRA_RPT_EDGE;
      else extra = EXTRA_RPT_MID;
    end else if (light_class) begin
      extra = EXTRA_LIGHT;
    end else begin
      extra = EXTRA_FULL;
    end
  end

  // Count the extra cycles down
  always_comb begin
    nxt_cnt = cnt_ff;
    if (start) nxt_cnt = extra;
    else if (cnt_ff != CNT_RST) nxt_cnt = cnt_ff - 2'h1;
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) cnt_ff <= CNT_RST;
    else cnt_ff <= nxt_cnt;
  end

  assign stall = (cnt_ff != CNT_RST);

endmodule

// ### rtl/dsd_decode.sv
// Data space decoder: routes X and Y bus accesses to the special area,
// the data RAM, the program window or unimplemented space.
// Assumes the address generation units and sequencer share the core clock,
// and that program memory answers a read with a valid pulse.
`timescale 1ns/1ps
module dsd_decode
  import dsd_pkg::*;
(
  input wire logic clock, // Core clock, 50 MHz
  input wire logic arst_n, // Async reset, active low
  input wire logic program_window_enable, // Window bit of core_control_reg
  input wire logic [PAGE_W-1:0] program_window_page, // Window page select
  input wire logic table_access, // Table read or write in progress
  input wire logic x_rd_req, // X read request
  input wire logic [ADDR_W-1:0] x_rd_addr, // X read byte address
  input wire logic x_rd_mac, // X read is a MAC prefetch
  input wire logic x_rd_bitrev, // X read asked for bit-reversed mode
  output logic x_rd_ready, // Decoder can take an X read
  output logic x_rd_valid, // X read data valid pulse
  output logic [DATA_W-1:0] x_rd_data, // X read data
  input wire logic y_rd_req, // Y read request
  input wire logic [ADDR_W-1:0] y_rd_addr, // Y read byte address
  input wire logic y_rd_mac, // Y read is a MAC prefetch
  input wire logic y_rd_bitrev, // Y read asked for bit-reversed mode
  output logic y_rd_valid, // Y read data valid pulse
  output logic [DATA_W-1:0] y_rd_data, // Y read data
  input wire logic x_wr_req, // X write request
  input wire logic [ADDR_W-1:0] x_wr_addr, // X write byte address
  input wire logic [DATA_W-1:0] x_wr_data, // X write data
  input wire logic [1:0] x_wr_be, // X write byte enables
  output logic sfr_rd_req, // Special area read strobe
  output logic [ADDR_W-1:0] sfr_rd_addr, // Special area read address
  input wire logic [DATA_W-1:0] sfr_rd_data, // Special area read data
  input wire logic sfr_rd_hit, // Special area location exists
  output logic sfr_wr_req, // Special area write strobe
  output logic [ADDR_W-1:0] sfr_wr_addr, // Special area write address
  output logic [DATA_W-1:0] sfr_wr_data, // Special area write data
  output logic [1:0] sfr_wr_be, // Special area write byte enables
  output logic prog_rd_req, // Program memory read request
  output logic [PROG_W-1:0] prog_rd_addr, // Program memory address
  input wire logic [PROG_W-1:0] prog_rd_data, // Program word
  input wire logic prog_rd_valid, // Program word valid pulse
  input wire logic instr_light, // MAC prefetch, move or double move
  input wire logic in_repeat, // Instruction inside repeat loop
  input wire logic rpt_first, // First repeat iteration
  input wire logic rpt_last, // Last repeat iteration
  input wire logic rpt_int_exit, // Leaving loop for interrupt
  input wire logic rpt_reentry, // Re-entering loop after interrupt
  output logic core_stall, // Extra instruction cycle request
  output logic addr_mode_err // Bit-reversed read refused pulse
);

  dsd_ram_if ram ();

  // Region flags for each port
  logic x_is_sfa;
  logic x_is_ram;
  logic x_is_y;
  logic x_is_upper;
  logic x_win;
  logic x_ram_ok;
  logic y_is_y;
  logic y_ok;
  logic w_is_sfa;
  logic w_is_ram;
  logic win_start;
  logic rpt_edge;

  // Registered state and outputs
  dsd_state_e state_ff;
  dsd_state_e nxt_state;
  logic [PROG_W-1:0] paddr_ff;
  logic [PROG_W-1:0] nxt_paddr;
  logic x_valid_ff;
  logic nxt_x_valid;
  logic [DATA_W-1:0] x_data_ff;
  logic [DATA_W-1:0] nxt_x_data;
  logic y_valid_ff;
  logic nxt_y_valid;
  logic [DATA_W-1:0] y_data_ff;
  logic [DATA_W-1:0] nxt_y_data;
  logic sw_req_ff;
  logic nxt_sw_req;
  logic [ADDR_W-1:0] sw_addr_ff;
  logic [ADDR_W-1:0] nxt_sw_addr;
  logic [DATA_W-1:0] sw_data_ff;
  logic [DATA_W-1:0] nxt_sw_data;
  logic [1:0] sw_be_ff;
  logic [1:0] nxt_sw_be;
  logic err_ff;
  logic nxt_err;

  // X port decode against the fixed map; addresses are byte addresses
  always_comb begin
    x_is_sfa = (x_rd_addr < SFA_LIMIT);
    x_is_ram = (x_rd_addr >= XRAM_BASE) && (x_rd_addr <= YRAM_LAST);
    x_is_y = (x_rd_addr >= YRAM_BASE) && (x_rd_addr <= YRAM_LAST);
    x_is_upper = (x_rd_addr >= WIN_BASE);
    // Window only while enabled and no table instruction owns program memory
    x_win = x_is_upper && program_window_enable && !table_access;
    // MAC reads see X without the Y block; others see the whole RAM
    x_ram_ok = x_is_ram && !(x_rd_mac && x_is_y);
  end

  // Y port decode: only the Y block, only MAC prefetch
  always_comb begin
    y_is_y = (y_rd_addr >= YRAM_BASE) && (y_rd_addr <= YRAM_LAST);
    y_ok = y_is_y && y_rd_mac && !y_rd_bitrev;
  end

  // X write decode; the upper half is never written through the window
  always_comb begin
    // Anything above the Y block is dropped without an answer
    w_is_sfa = (x_wr_addr < SFA_LIMIT);
    w_is_ram = (x_wr_addr >= XRAM_BASE) && (x_wr_addr <= YRAM_LAST);
  end

  // Repeat boundaries that cost the full two extra cycles
  assign rpt_edge = rpt_first || rpt_last || rpt_int_exit || rpt_reentry;

  // Ready drops while a window fetch is outstanding, so only one is in flight
  assign x_rd_ready = (state_ff == DSD_IDLE);
  assign win_start = x_rd_req && x_rd_ready && x_win && !x_rd_bitrev;

  // RAM word index from the byte address; the low bit is dropped and whole words are read
  assign ram.x_idx = x_rd_addr[IDX_W:1];
  assign ram.y_idx = y_rd_addr[IDX_W:1];
  assign ram.wr_en = x_wr_req && w_is_ram;
  assign ram.wr_idx = x_wr_addr[IDX_W:1];
  assign ram.wr_data = x_wr_data;
  assign ram.wr_be = x_wr_be;

  // Special area read answers in the same cycle
  assign sfr_rd_req = x_rd_req && x_rd_ready && x_is_sfa && !x_rd_bitrev;
  assign sfr_rd_addr = x_rd_addr;

  // Window state and program address
  always_comb begin
    nxt_state = state_ff;
    nxt_paddr = paddr_ff;
    unique case (state_ff)
      DSD_IDLE: begin
        if (win_start) begin
          // Page supplies bits 22 to 15, the address the low 15; bit 23 is zero
          nxt_paddr = {1'b0, program_window_page, x_rd_addr[WIN_LOW_W-1:0]};
          nxt_state = DSD_WAIT;
        end
      end
      DSD_WAIT: begin
        // Ready is low here, so the held program address cannot be overwritten
        if (prog_rd_valid) nxt_state = DSD_IDLE;
      end
      default: begin
        // Illegal one-hot codes fall back to idle
        nxt_state = DSD_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      state_ff <= DSD_IDLE;
      paddr_ff <= PADDR_RST;
    end else begin
      state_ff <= nxt_state;
      paddr_ff <= nxt_paddr;
    end
  end

  // Fetch request stands until program memory answers
  assign prog_rd_req = (state_ff == DSD_WAIT);
  assign prog_rd_addr = paddr_ff;

  // X read return: zero for anything outside what this access may see
  always_comb begin
    nxt_x_valid = 1'b0;
    nxt_x_data = x_data_ff;
    if (state_ff == DSD_WAIT) begin
      if (prog_rd_valid) begin
        nxt_x_valid = 1'b1;
        // Upper byte of the program word is dropped, never returned
        nxt_x_data = prog_rd_data[DATA_W-1:0];
      end
    end else if (x_rd_req && !win_start) begin
      // Reached only outside a fetch, so the request is accepted
      nxt_x_valid = 1'b1;
      // A refused bit-reversed read still answers, with zero
      if (x_rd_bitrev) nxt_x_data = DATA_RST;
      else if (x_ram_ok) nxt_x_data = ram.x_q;
      else if (x_is_sfa && sfr_rd_hit) nxt_x_data = sfr_rd_data;
      else nxt_x_data = DATA_RST;
    end
  end

  // X return registers; data holds from one answer to the next
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      x_valid_ff <= 1'b0;
      x_data_ff <= DATA_RST;
    end else begin
      x_valid_ff <= nxt_x_valid;
      x_data_ff <= nxt_x_data;
    end
  end

  // X answer leaves straight from its flip-flops
  assign x_rd_valid = x_valid_ff;
  assign x_rd_data = x_data_ff;

  // Y read return, concurrent with the X read of a MAC instruction
  always_comb begin
    nxt_y_valid = y_rd_req;
    nxt_y_data = y_data_ff;
    if (y_rd_req) begin
      // The Y bus never waits, so every request answers next cycle
      if (y_ok) nxt_y_data = ram.y_q;
      else nxt_y_data = DATA_RST;
    end
  end

  // Y return registers
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      y_valid_ff <= 1'b0;
      y_data_ff <= DATA_RST;
    end else begin
      y_valid_ff <= nxt_y_valid;
      y_data_ff <= nxt_y_data;
    end
  end

  // Y answer leaves straight from its flip-flops
  assign y_rd_valid = y_valid_ff;
  assign y_rd_data = y_data_ff;

  // Bit-reversed mode is refused on either read bus
  always_comb begin
    // The Y bus has no ready, so its refusal is never gated
    nxt_err = (x_rd_req && x_rd_ready && x_rd_bitrev) || (y_rd_req && y_rd_bitrev);
  end

  // Refusal pulse register
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) err_ff <= 1'b0;
    else err_ff <= nxt_err;
  end

  // Refusal pulse output
  assign addr_mode_err = err_ff;

  // Special area writes leave from flip-flops one cycle after the request
  always_comb begin
    nxt_sw_req = x_wr_req && w_is_sfa;
    nxt_sw_addr = sw_addr_ff;
    nxt_sw_data = sw_data_ff;
    nxt_sw_be = sw_be_ff;
    // Address, data and lanes hold between strobes
    if (x_wr_req && w_is_sfa) begin
      nxt_sw_addr = x_wr_addr;
      nxt_sw_data = x_wr_data;
      nxt_sw_be = x_wr_be;
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      sw_req_ff <= 1'b0;
      sw_addr_ff <= DATA_RST;
      sw_data_ff <= DATA_RST;
      sw_be_ff <= 2'h0;
    end else begin
      sw_req_ff <= nxt_sw_req;
      sw_addr_ff <= nxt_sw_addr;
      sw_data_ff <= nxt_sw_data;
      sw_be_ff <= nxt_sw_be;
    end
  end

  // Special area write port straight from its flip-flops
  assign sfr_wr_req = sw_req_ff;
  assign sfr_wr_addr = sw_addr_ff;
  assign sfr_wr_data = sw_data_ff;
  assign sfr_wr_be = sw_be_ff;

  // Word storage for X and Y RAM
  dsd_ram u_ram (
    .clock(clock),
    .arst_n(arst_n),
    .ram(ram.mem)
  );

  // Extra-cycle accounting for each windowed access
  dsd_cycle u_cycle (
    .clock(clock),
    .arst_n(arst_n),
    .start(win_start),
    .light_class(instr_light),
    .in_repeat(in_repeat),
    .rpt_edge(rpt_edge),
    .stall(core_stall)
  );

endmodule

// ### sim/dsd_decode_sva.sv
// Checker for the data space decoder, bound to its top ports.
// Assumes one core clock and the active-low asynchronous reset.
`timescale 1ns/1ps
module dsd_decode_chk
  import dsd_pkg::*;
(
  input wire logic clock, arst_n, program_window_enable, table_access, // Clock, reset, window
  input wire logic [PAGE_W-1:0] program_window_page, // Page
  input wire logic x_rd_req, x_rd_mac, x_rd_bitrev, x_rd_ready, x_rd_valid, // X read
  input wire logic [ADDR_W-1:0] x_rd_addr, y_rd_addr, x_wr_addr, // Addresses
  input wire logic [ADDR_W-1:0] sfr_rd_addr, sfr_wr_addr, // Special area addresses
  input wire logic [DATA_W-1:0] x_rd_data, y_rd_data, x_wr_data, sfr_wr_data, // Data
  input wire logic y_rd_req, y_rd_mac, y_rd_valid, x_wr_req, sfr_rd_req, sfr_wr_req, // Strobes
  input wire logic prog_rd_req, prog_rd_valid, core_stall, addr_mode_err, // Status
  input wire logic [PROG_W-1:0] prog_rd_addr, prog_rd_data, // Program bus
  input wire logic instr_light, in_repeat, rpt_first, rpt_last, rpt_int_exit, rpt_reentry // Class
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!arst_n);
  logic rpt_edge;
  logic x_take;
  logic [PROG_W-1:0] win_addr;
  logic [DATA_W-1:0] prog_lo;
  // Helper terms shared by the properties
  assign rpt_edge = rpt_first | rpt_last | rpt_int_exit | rpt_reentry;
  assign x_take = x_rd_req & x_rd_ready & ~x_rd_bitrev;
  assign win_addr = {1'b0, program_window_page, x_rd_addr[14:0]};
  assign prog_lo = prog_rd_data[15:0];
  // Accepted window read, two-cycle stall, zero answer
  sequence s_win;
    x_take && x_rd_addr[15] && program_window_enable && !table_access;
  endsequence
  sequence s_two;
    core_stall [*2] ##1 !core_stall;
  endsequence
  sequence s_zero;
    x_rd_valid && x_rd_data == 16'h0000 && !prog_rd_req;
  endsequence
  property p_win_addr;
    s_win |=> prog_rd_req && prog_rd_addr == $past(win_addr);
  endproperty
  a_win_addr: assert property (p_win_addr) else $error("window address");
  property p_win_data;
    prog_rd_req && prog_rd_valid |=> x_rd_valid && x_rd_data == $past(prog_lo);
  endproperty
  a_win_data: assert property (p_win_data) else $error("window data");
  property p_light;
    s_win ##0 (instr_light && !in_repeat) |=> core_stall ##1 !core_stall;
  endproperty
  a_light: assert property (p_light) else $error("light stall");
  property p_full;
    s_win ##0 (!instr_light && !in_repeat) |=> s_two;
  endproperty
  a_full: assert property (p_full) else $error("full stall");
  property p_rpt_edge;
    s_win ##0 (in_repeat && rpt_edge) |=> s_two;
  endproperty
  a_rpt_edge: assert property (p_rpt_edge) else $error("repeat edge stall");
  property p_rpt_mid;
    s_win ##0 (in_repeat && !rpt_edge) |=> !core_stall [*2];
  endproperty
  a_rpt_mid: assert property (p_rpt_mid) else $error("repeat mid stall");
  property p_win_off;
    x_take && x_rd_addr[15] && (!program_window_enable || table_access) |=> s_zero;
  endproperty
  a_win_off: assert property (p_win_off) else $error("window off");
  property p_sfr_rd;
    x_take && x_rd_addr < SFA_LIMIT |-> sfr_rd_req && sfr_rd_addr == x_rd_addr;
  endproperty
  a_sfr_rd: assert property (p_sfr_rd) else $error("special read");
  property p_mac_x;
    x_take && x_rd_mac && x_rd_addr >= YRAM_BASE && x_rd_addr <= YRAM_LAST |=> s_zero;
  endproperty
  a_mac_x: assert property (p_mac_x) else $error("mac x in y");
  property p_y_ref;
    y_rd_req && (!y_rd_mac || y_rd_addr < YRAM_BASE || y_rd_addr > YRAM_LAST)
      |=> y_rd_valid && y_rd_data == 16'h0000;
  endproperty
  a_y_ref: assert property (p_y_ref) else $error("y refuse");
  property p_bitrev;
    x_rd_req && x_rd_ready && x_rd_bitrev |=> addr_mode_err ##0 s_zero;
  endproperty
  a_bitrev: assert property (p_bitrev) else $error("bitrev read");
  property p_sfr_wr;
    x_wr_req && x_wr_addr < SFA_LIMIT |=> sfr_wr_req && sfr_wr_addr == $past(x_wr_addr)
      && sfr_wr_data == $past(x_wr_data);
  endproperty
  a_sfr_wr: assert property (p_sfr_wr) else $error("special write");
endmodule
bind dsd_decode dsd_decode_chk i_chk (.*);

// ### sim/dsd_prog_model.sv
// Program memory and special area stand-in on the decoder's far side.
// Assumes prog_rd_req stays high until the valid pulse is seen.
`timescale 1ns/1ps
module dsd_prog_model
  import dsd_pkg::*;
(
  input wire logic clock, // Core clock
  input wire logic arst_n, // Async reset
  input wire logic prog_rd_req, // Fetch request
  input wire logic [PROG_W-1:0] prog_rd_addr, // Fetch address
  output logic [PROG_W-1:0] prog_rd_data, // Program word
  output logic prog_rd_valid, // Word valid pulse
  input wire logic [ADDR_W-1:0] sfr_rd_addr, // Special area address
  output logic [DATA_W-1:0] sfr_rd_data, // Special area data
  output logic sfr_rd_hit, // Location exists
  input wire logic [3:0] lat // Extra wait cycles
);
  logic [3:0] wait_ff;
  logic [PROG_W-1:0] word;
  // Upper byte all ones acts as an illegal opcode
  assign word = {8'hff, prog_rd_addr[23:8] ^ prog_rd_addr[15:0]};
  // Word shown only with valid, inverted otherwise
  assign prog_rd_data = prog_rd_valid ? word : ~word;
  // Only the lowest 256 bytes of the special area exist
  assign sfr_rd_hit = sfr_rd_addr < 16'h0100;
  assign sfr_rd_data = sfr_rd_hit ? (sfr_rd_addr ^ 16'hc3c3) : ~sfr_rd_addr;
  // Answer each fetch after lat extra cycles
  always @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      wait_ff <= 4'h0;
      prog_rd_valid <= 1'b0;
    end else begin
      prog_rd_valid <= 1'b0;
      if (prog_rd_req && !prog_rd_valid) begin
        if (wait_ff >= lat) begin
          prog_rd_valid <= 1'b1;
          wait_ff <= 4'h0;
        end else begin
          wait_ff <= wait_ff + 4'h1;
        end
      end
    end
  end
endmodule

// ### sim/testbench.sv
// Self-checking bench for the data space decoder.
// Assumes the program memory model answers window fetches.
`timescale 1ns/1ps
module testbench;
  import dsd_pkg::*;
  logic clock, arst_n, program_window_enable, table_access, x_rd_req, x_rd_mac, x_rd_bitrev;
  logic x_rd_ready, x_rd_valid, y_rd_req, y_rd_mac, y_rd_bitrev, y_rd_valid, x_wr_req;
  logic sfr_rd_req, sfr_rd_hit, sfr_wr_req, prog_rd_req, prog_rd_valid, core_stall;
  logic instr_light, in_repeat, rpt_first, rpt_last, rpt_int_exit, rpt_reentry, addr_mode_err;
  logic [7:0] program_window_page;
  logic [15:0] x_rd_addr, x_rd_data, y_rd_addr, y_rd_data, x_wr_addr, x_wr_data;
  logic [15:0] sfr_rd_addr, sfr_rd_data, sfr_wr_addr, sfr_wr_data;
  logic [1:0] x_wr_be, sfr_wr_be;
  logic [23:0] prog_rd_addr, prog_rd_data;
  logic [3:0] lat;
  logic [15:0] q, r;
  int n_mismatch, checks, n;
  dsd_decode i_dut (.*);
  dsd_prog_model i_mem (.*);
  // Core clock, 20 ns period
  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic results();
    $display("checks=%0d mismatches=%0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // X read; counts stall cycles until the answer
  task automatic x_read(input logic [15:0] a, input logic [1:0] mb, input logic [5:0] c);
    @(posedge clock);
    x_rd_req <= 1'b1;
    x_rd_addr <= a;
    {x_rd_mac, x_rd_bitrev} <= mb;
    {instr_light, in_repeat, rpt_first, rpt_last, rpt_int_exit, rpt_reentry} <= c;
    @(posedge clock);
    x_rd_req <= 1'b0;
    #1;
    n = 0;
    for (int i = 0; i < 20 && x_rd_valid !== 1'b1; i++) begin
      n += int'(core_stall === 1'b1);
      @(posedge clock);
      #1;
    end
    n += int'(core_stall === 1'b1);
    check({15'h0, x_rd_valid}, 16'h0001);
    q = x_rd_data;
  endtask
  task automatic y_read(input logic [15:0] a, input logic [1:0] mb);
    @(posedge clock);
    y_rd_req <= 1'b1;
    y_rd_addr <= a;
    {y_rd_mac, y_rd_bitrev} <= mb;
    @(posedge clock);
    y_rd_req <= 1'b0;
    #1;
    r = y_rd_valid ? y_rd_data : 16'hdead;
  endtask
  task automatic x_write(input logic [15:0] a, input logic [15:0] v, input logic [1:0] be);
    @(posedge clock);
    x_wr_req <= 1'b1;
    x_wr_addr <= a;
    x_wr_data <= v;
    x_wr_be <= be;
    @(posedge clock);
    x_wr_req <= 1'b0;
    #1;
  endtask
  // RAM, special area and unimplemented space
  task automatic t_map();
    x_write(16'h0800, 16'h1234, 2'h3);
    x_write(16'h09fe, 16'habcd, 2'h3);
    x_write(16'h09fe, 16'h55ef, 2'h1);
    x_read(16'h0801, 2'h0, 6'h0);
    check(q, 16'h1234);
    x_read(16'h09fe, 2'h0, 6'h0);
    check(q, 16'habef);
    x_write(16'h0010, 16'hbeef, 2'h2);
    check({13'h0, sfr_wr_req, sfr_wr_be}, 16'h0006);
    check(sfr_wr_data, 16'hbeef);
    check(sfr_wr_addr, 16'h0010);
    x_write(16'h0a00, 16'h1111, 2'h3);
    check({15'h0, sfr_wr_req}, 16'h0);
    x_read(16'h0020, 2'h0, 6'h0);
    check(q, 16'h0020 ^ 16'hc3c3);
    x_read(16'h0700, 2'h0, 6'h0);
    check(q, 16'h0);
    x_read(16'h0a00, 2'h0, 6'h0);
    check(q, 16'h0);
    $display("t_map done");
  endtask
  // Concurrent X and Y reads and cross-space pointers
  task automatic t_mac();
    x_write(16'h0900, 16'h4321, 2'h3);
    x_write(16'h0802, 16'h8765, 2'h3);
    fork
      x_read(16'h0802, 2'h2, 6'h0);
      y_read(16'h0900, 2'h2);
    join
    check(q, 16'h8765);
    check(r, 16'h4321);
    x_read(16'h0900, 2'h2, 6'h0);
    check(q, 16'h0);
    x_read(16'h0900, 2'h0, 6'h0);
    check(q, 16'h4321);
    y_read(16'h0802, 2'h2);
    check(r, 16'h0);
    y_read(16'h0900, 2'h0);
    check(r, 16'h0);
    y_read(16'h0900, 2'h3);
    check(r, 16'h0);
    check({15'h0, addr_mode_err}, 16'h1);
    $display("t_mac done");
  endtask
  // Window reads over every class and repeat case
  task automatic t_win();
    logic [47:0] tbl;
    logic [23:0] pa;
    logic [15:0] a;
    logic [5:0] c;
    int e;
    tbl = {6'h20, 6'h00, 6'h18, 6'h14, 6'h12, 6'h11, 6'h10, 6'h30};
    for (int i = 0; i < 8; i++) begin
      @(posedge clock);
      c = tbl[6*i +: 6];
      a = i[0] ? 16'hfffe : 16'h8000 + 16'(i * 6);
      program_window_enable <= 1'b1;
      program_window_page <= 8'ha5 ^ 8'(i * 37);
      lat <= 4'(i % 4);
      x_read(a, 2'h0, c);
      pa = {1'b0, program_window_page, a[14:0]};
      e = c[4] ? ((c[3:0] != 4'h0) ? 2 : 0) : (c[5] ? 1 : 2);
      check(q, pa[23:8] ^ pa[15:0]);
      check(16'(n), 16'(e));
    end
    @(posedge clock);
    table_access <= 1'b1;
    x_read(16'h8000, 2'h0, 6'h0);
    check(q, 16'h0);
    @(posedge clock);
    table_access <= 1'b0;
    program_window_enable <= 1'b0;
    x_read(16'hc000, 2'h0, 6'h0);
    check(q, 16'h0);
    x_read(16'h0800, 2'h1, 6'h0);
    check({15'h0, addr_mode_err}, 16'h1);
    check(q, 16'h0);
    $display("t_win done");
  endtask
  initial begin
    {arst_n, program_window_enable, table_access, x_rd_req, x_rd_mac, x_rd_bitrev} = '0;
    {y_rd_req, y_rd_mac, y_rd_bitrev, x_wr_req, instr_light, in_repeat} = '0;
    {rpt_first, rpt_last, rpt_int_exit, rpt_reentry} = '0;
    {program_window_page, x_rd_addr, y_rd_addr, x_wr_addr, x_wr_data, x_wr_be, lat} = '0;
    repeat (5) @(posedge clock);
    arst_n <= 1'b1;
    @(posedge clock);
    #1;
    check({12'h0, x_rd_valid, core_stall, prog_rd_req, x_rd_ready}, 16'h1);
    t_map();
    t_mac();
    t_win();
    results();
  end
  // Watchdog well beyond the expected run
  initial begin
    #50000;
    n_mismatch++;
    $display("watchdog expired");
    results();
  end
endmodule
